// >>> motion_cmd_defs.svh
// Constants of the motion interrupt command unit
`ifndef MOTION_CMD_DEFS_SVH
`define MOTION_CMD_DEFS_SVH
// Command codes
`define CMD_RESET 8'h00
`define CMD_WIDTH_EIGHT 8'h05
`define CMD_WIDTH_TWELVE 8'h06
`define CMD_HOME_DEFINE 8'h02
`define CMD_INDEX_ARM 8'h03
`define CMD_THR_FLAG 8'h1B
`define CMD_THR_STOP 8'h1A
`define CMD_BP_ABS 8'h20
`define CMD_BP_REL 8'h21
`define CMD_MASK_LOAD 8'h1C
`define CMD_FLAG_CLEAR 8'h1D
// Register byte offsets
`define OFS_CMD_STATUS 5'h00
`define OFS_DATA 5'h04
`define OFS_INDEX_POS 5'h08
`define OFS_MASK 5'h0C
`define OFS_THRESHOLD 5'h10
`define OFS_BREAKPOINT 5'h14
`define OFS_CONFIG 5'h18
// Status bit positions
`define BIT_BUSY 0
`define BIT_CMD_ERR 1
`define BIT_TRAJ 2
`define BIT_INDEX 3
`define BIT_WRAP 4
`define BIT_POS_ERR 5
`define BIT_BREAK 6
// Reset values and codes
`define MASK_RESET 6'h00
`define ZERO_CODE8 8'h80
`define ZERO_CODE12 12'h800
// Busy time after a command or data word
`define BUSY_TIME_NS 15000
`define CLK_PERIOD_NS 10
`define BUSY_CYCLES (`BUSY_TIME_NS / `CLK_PERIOD_NS)
`endif

// >>> motion_cmd_pkg.sv
// Types of the motion interrupt command unit
package motion_cmd_pkg;
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_COLLECT
    } cmd_state_t;
    typedef logic [5:0] flag_vec_t;
endpackage : motion_cmd_pkg

// >>> motion_interrupt_command_unit.sv
// Command decoder for width, home and interrupt control of a servo controller
// ==========================================================================
`timescale 1ns/10ps
`include "motion_cmd_defs.svh"
module motion_interrupt_command_unit
    import motion_cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_index,
    input wire logic [31:0] raw_position,
    input wire logic [31:0] target_position,
    input wire logic signed [15:0] position_error,
    input wire logic [15:0] filter_drive,
    input wire logic traj_done_evt,
    input wire logic wrap_evt,
    input wire logic cmd_err_evt,
    output logic [31:0] abs_position,
    output logic [11:0] motor_code,
    output logic width_twelve,
    output logic host_irq
);
    default clocking dclk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ======================================================================
    // Decode helpers
    function automatic logic [2:0] data_bytes_for(input logic [7:0] code);
        case (code)
            `CMD_THR_FLAG, `CMD_THR_STOP, `CMD_MASK_LOAD, `CMD_FLAG_CLEAR: data_bytes_for = 3'd2;
            `CMD_BP_ABS, `CMD_BP_REL: data_bytes_for = 3'd4;
            default: data_bytes_for = 3'd0;
        endcase
    endfunction : data_bytes_for
    // ======================================================================
    // Bus slave
    logic ack_r;
    logic take;
    logic busy;
    logic cmd_take;
    logic data_take;
    logic [7:0] wbyte;
    assign waitrequest = (read | write) & ~ack_r;
    assign take = (read | write) & ack_r;
    assign wbyte = writedata[7:0];
    assign cmd_take = take & write & (address == `OFS_CMD_STATUS);
    assign data_take = take & write & (address == `OFS_DATA) & ~busy;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read | write) & ~ack_r;
        end
    end
    // ======================================================================
    // Encoder pin synchronisers
    logic [2:0] enc_meta_r;
    logic [2:0] enc_sync_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_meta_r <= 3'h7;
            enc_sync_r <= 3'h7;
        end else begin
            enc_meta_r <= {enc_index, enc_b, enc_a};
            enc_sync_r <= enc_meta_r;
        end
    end
    // ======================================================================
    // Command sequencing
    cmd_state_t state_r;
    logic [7:0] cmd_r;
    logic [2:0] need_r;
    logic [2:0] cnt_r;
    logic [23:0] data_r;
    logic [31:0] data_cat;
    logic exec_data;
    logic cmd_ok;
    assign data_cat = {data_r, wbyte};
    assign cmd_ok = cmd_take & ~busy;
    assign exec_data = data_take & (state_r == ST_COLLECT) & (cnt_r + 3'd1 == need_r);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cmd_r <= 8'h00;
            need_r <= 3'd0;
            cnt_r <= 3'd0;
            data_r <= 24'h000000;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_ok && data_bytes_for(wbyte) != 3'd0) begin
                        state_r <= ST_COLLECT;
                        cmd_r <= wbyte;
                        need_r <= data_bytes_for(wbyte);
                        cnt_r <= 3'd0;
                    end
                end
                ST_COLLECT: begin
                    if (cmd_ok) begin
                        state_r <= (data_bytes_for(wbyte) != 3'd0) ? ST_COLLECT : ST_IDLE;
                        cmd_r <= wbyte;
                        need_r <= data_bytes_for(wbyte);
                        cnt_r <= 3'd0;
                    end else if (data_take) begin
                        data_r <= data_cat[23:0];
                        cnt_r <= cnt_r + 3'd1;
                        if (exec_data) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
    // Busy after a command byte or the second byte of a data word
    logic [10:0] busy_cnt_r;
    assign busy = (busy_cnt_r != 11'd0);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_r <= 11'd0;
        end else if (cmd_ok || (data_take && cnt_r[0])) begin
            busy_cnt_r <= 11'(`BUSY_CYCLES);
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 11'd1;
        end
    end
    // ======================================================================
    // Width select and home
    logic soft_reset;
    logic width_twelve_r;
    logic [31:0] home_r;
    assign soft_reset = cmd_ok & (wbyte == `CMD_RESET);
    assign width_twelve = width_twelve_r;
    assign abs_position = raw_position - home_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            width_twelve_r <= 1'b0;
        end else if (soft_reset || (cmd_ok && wbyte == `CMD_WIDTH_EIGHT)) begin
            width_twelve_r <= 1'b0;
        end else if (cmd_ok && wbyte == `CMD_WIDTH_TWELVE) begin
            width_twelve_r <= 1'b1;
        end
    end
    // Target position is never touched here
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            home_r <= 32'h00000000;
        end else if (soft_reset || (cmd_ok && wbyte == `CMD_HOME_DEFINE)) begin
            home_r <= raw_position;
        end
    end
    // ======================================================================
    // Index capture
    logic index_armed_r;
    logic index_hit;
    logic [31:0] index_pos_r;
    assign index_hit = index_armed_r & (enc_sync_r == 3'h0);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            index_armed_r <= 1'b0;
            index_pos_r <= 32'h00000000;
        end else if (index_hit) begin
            index_armed_r <= 1'b0;
            index_pos_r <= abs_position;
        end else if (cmd_ok && wbyte == `CMD_INDEX_ARM) begin
            index_armed_r <= 1'b1;
        end
    end
    // ======================================================================
    // Position error threshold
    logic [14:0] thresh_r;
    logic stop_mode_r;
    logic stop_r;
    logic [15:0] err_mag;
    logic err_hit;
    assign err_mag = position_error[15] ? 16'(-position_error) : position_error;
    assign err_hit = (err_mag > {1'b0, thresh_r});
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thresh_r <= 15'h7FFF;
            stop_mode_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (soft_reset) begin
            stop_mode_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (exec_data && (cmd_r == `CMD_THR_FLAG || cmd_r == `CMD_THR_STOP)) begin
            thresh_r <= data_cat[14:0];
            stop_mode_r <= (cmd_r == `CMD_THR_STOP);
            stop_r <= 1'b0;
        end else if (stop_mode_r && err_hit) begin
            stop_r <= 1'b1;
        end
    end
    // ======================================================================
    // Breakpoint
    logic [31:0] bp_r;
    logic bp_armed_r;
    logic bp_hit;
    assign bp_hit = bp_armed_r & (abs_position == bp_r);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_r <= 32'h00000000;
            bp_armed_r <= 1'b0;
        end else if (exec_data && cmd_r == `CMD_BP_ABS) begin
            bp_r <= data_cat;
            bp_armed_r <= 1'b1;
        end else if (exec_data && cmd_r == `CMD_BP_REL) begin
            bp_r <= target_position + data_cat;
            bp_armed_r <= 1'b1;
        end else if (bp_hit) begin
            bp_armed_r <= 1'b0;
        end
    end
    // ======================================================================
    // Flags, mask and interrupt
    flag_vec_t flag_r;
    flag_vec_t mask_r;
    flag_vec_t flag_set;
    logic clr_exec;
    assign flag_set = {bp_hit, err_hit, wrap_evt, index_hit, traj_done_evt, cmd_err_evt};
    assign clr_exec = exec_data & (cmd_r == `CMD_FLAG_CLEAR);
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    flag_r[gi] <= 1'b0;
                end else if (flag_set[gi]) begin
                    flag_r[gi] <= 1'b1;
                end else if (clr_exec && !data_cat[gi + 1]) begin
                    flag_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= `MASK_RESET;
        end else if (soft_reset) begin
            mask_r <= `MASK_RESET;
        end else if (exec_data && cmd_r == `CMD_MASK_LOAD) begin
            mask_r <= data_cat[6:1];
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_irq <= 1'b0;
        end else begin
            host_irq <= |(flag_r & mask_r);
        end
    end
    // ======================================================================
    // Motor output, offset binary
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            motor_code <= {4'h0, `ZERO_CODE8};
        end else if (stop_r || soft_reset) begin
            motor_code <= width_twelve_r ? `ZERO_CODE12 : {4'h0, `ZERO_CODE8};
        end else if (width_twelve_r) begin
            motor_code <= filter_drive[15:4] ^ `ZERO_CODE12;
        end else begin
            motor_code <= {4'h0, filter_drive[15:8] ^ `ZERO_CODE8};
        end
    end
    // ======================================================================
    // Read data
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h00000000;
        end else if (read && !ack_r) begin
            case (address)
                `OFS_CMD_STATUS: readdata <= {24'h000000, 1'b0, flag_r, busy};
                `OFS_INDEX_POS: readdata <= index_pos_r;
                `OFS_MASK: readdata <= {25'h0000000, mask_r, 1'b0};
                `OFS_THRESHOLD: readdata <= {17'h00000, thresh_r};
                `OFS_BREAKPOINT: readdata <= bp_r;
                `OFS_CONFIG: readdata <= {28'h0000000, stop_r, stop_mode_r, index_armed_r,
                    width_twelve_r};
                default: readdata <= 32'h00000000;
            endcase
        end
    end
    // ======================================================================
    // Assertions
    property p_width_eight;
        cmd_ok && wbyte == `CMD_WIDTH_EIGHT |=> !width_twelve_r;
    endproperty
    a_width_eight: assert property (p_width_eight) else $error("width 8 not selected");
    property p_width_twelve;
        cmd_ok && wbyte == `CMD_WIDTH_TWELVE |=> width_twelve_r ##1
            ($past(stop_r) || motor_code == ($past(filter_drive[15:4]) ^ `ZERO_CODE12));
    endproperty
    a_width_twelve: assert property (p_width_twelve) else $error("width 12 not selected");
    property p_busy_ignore;
        cmd_take && busy |=> $stable(width_twelve_r) && $stable(home_r) && $stable(state_r);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");
    property p_home;
        cmd_ok && wbyte == `CMD_HOME_DEFINE |=> home_r == $past(raw_position);
    endproperty
    a_home: assert property (p_home) else $error("home not defined");
    property p_index;
        index_armed_r && enc_sync_r == 3'h0 |=> flag_r[`BIT_INDEX - 1]
            && index_pos_r == $past(abs_position) && !index_armed_r;
    endproperty
    a_index: assert property (p_index) else $error("index not captured");
    property p_err;
        err_hit |=> flag_r[`BIT_POS_ERR - 1];
    endproperty
    a_err: assert property (p_err) else $error("error flag missing");
    property p_stop;
        stop_mode_r && err_hit && !soft_reset && !exec_data |=> ##1
            (motor_code == ($past(width_twelve_r) ? `ZERO_CODE12 : {4'h0, `ZERO_CODE8}));
    endproperty
    a_stop: assert property (p_stop) else $error("drive not zeroed");
    property p_irq;
        ##1 host_irq == |($past(flag_r) & $past(mask_r));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not gated by mask");
    property p_status;
        read && !ack_r && address == `OFS_CMD_STATUS |=> readdata[6:1] == $past(flag_r);
    endproperty
    a_status: assert property (p_status) else $error("status misses a flag");
    property p_bp;
        bp_hit |=> flag_r[`BIT_BREAK - 1] && !bp_armed_r;
    endproperty
    a_bp: assert property (p_bp) else $error("breakpoint flag missing");
    c_index: cover property (index_hit);
    c_bp: cover property (bp_hit);
    c_irq: cover property ($rose(host_irq));
endmodule : motion_interrupt_command_unit

// >>> enc_model.sv
// Encoder and position source facing the command unit
`timescale 1ns/10ps

module enc_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic move,
    input wire logic load,
    input wire logic [31:0] load_val,
    output logic [31:0] raw_position,
    output logic enc_a,
    output logic enc_b,
    output logic enc_index
);
    logic [2:0] tick_r;

    // ==========
    // Position count, one step every 8 cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_position <= 32'h000000F0;
            tick_r <= 3'h0;
        end else if (load) begin
            raw_position <= load_val;
        end else if (move) begin
            tick_r <= tick_r + 3'h1;
            if (tick_r == 3'h7) begin
                raw_position <= raw_position + 32'h1;
            end
        end
    end

    // ==========
    // Phases both low at count 00, index low once per 256
    assign enc_a = raw_position[1];
    assign enc_b = raw_position[1] ^ raw_position[0];
    assign enc_index = |raw_position[7:2];
endmodule : enc_model

// >>> testbench.sv
// Self-checking bench of the motion interrupt command unit
`timescale 1ns/10ps
`include "motion_cmd_defs.svh"

module testbench;
    logic core_clk, rst_n, read, write, waitrequest, width_twelve, host_irq;
    logic enc_a, enc_b, enc_index, traj_done_evt, wrap_evt, cmd_err_evt, move, load;
    logic [4:0] address;
    logic [31:0] writedata, readdata, raw_position, target_position, abs_position, load_val;
    logic signed [15:0] position_error;
    logic [15:0] filter_drive, t;
    logic [11:0] motor_code;
    logic [31:0] q, p, x, b, o, ef;
    logic [7:0] m;
    int n_fail, checks, seed, bits[3];

    motion_interrupt_command_unit motion_interrupt_command_unit_i (
        .core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .enc_a(enc_a), .enc_b(enc_b),
        .enc_index(enc_index), .raw_position(raw_position),
        .target_position(target_position), .position_error(position_error),
        .filter_drive(filter_drive), .traj_done_evt(traj_done_evt),
        .wrap_evt(wrap_evt), .cmd_err_evt(cmd_err_evt),
        .abs_position(abs_position), .motor_code(motor_code),
        .width_twelve(width_twelve), .host_irq(host_irq)
    );

    enc_model enc_model_i (
        .core_clk(core_clk), .rst_n(rst_n), .move(move), .load(load),
        .load_val(load_val), .raw_position(raw_position), .enc_a(enc_a),
        .enc_b(enc_b), .enc_index(enc_index)
    );

    // ==========
    // Clock and watchdog
    always #5 core_clk = ~core_clk;

    initial begin
        repeat (90000) @(posedge core_clk);
        fail_out();
    end

    // ==========
    // Report tasks
    task automatic test_done;
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic fail_out;
        n_fail++;
        $display("CHECK FAILED %0t wait timed out", $time);
        test_done();
    endtask : fail_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [11:0] exp_motor(input logic twelve, input logic [15:0] fd);
        exp_motor = twelve ? (fd[15:4] ^ `ZERO_CODE12) : {4'h0, fd[15:8] ^ `ZERO_CODE8};
    endfunction : exp_motor

    // ==========
    // Avalon master tasks
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rq = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) fail_out();
    endtask : bus

    task automatic rd(input logic [4:0] a);
        bus(1'b0, a, 32'h0, q);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] dq;
        bus(1'b1, a, {24'h0, d}, dq);
    endtask : wr

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            rd(`OFS_CMD_STATUS);
            n++;
        end while (q[`BIT_BUSY] !== 1'b0 && n < 1000);
        if (q[`BIT_BUSY] !== 1'b0) fail_out();
    endtask : wait_idle

    task automatic cmd(input logic [7:0] c);
        wait_idle();
        wr(`OFS_CMD_STATUS, c);
        wait_idle();
    endtask : cmd

    task automatic word(input logic [15:0] w);
        wait_idle();
        wr(`OFS_DATA, w[15:8]);
        wr(`OFS_DATA, w[7:0]);
        wait_idle();
    endtask : word

    task automatic flags;
        rd(`OFS_CMD_STATUS);
        q = q & 32'h7E;
    endtask : flags

    task automatic set_raw(input logic [31:0] v);
        @(posedge core_clk);
        load <= 1'b1;
        load_val <= v;
        @(posedge core_clk);
        load <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : set_raw

    // ==========
    // Main sequence
    initial begin
        seed = 99;
        bits = '{1, 2, 4};
        core_clk = 1'b0;
        rst_n = 1'b0;
        {read, write, traj_done_evt, wrap_evt, cmd_err_evt, move, load} = 7'h00;
        address = 5'h00;
        writedata = 32'h0;
        load_val = 32'h0;
        target_position = 32'h0;
        position_error = 16'sh0000;
        filter_drive = 16'h0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        filter_drive <= 16'($random(seed));
        chk(width_twelve, 1'b0);
        chk(motor_code, 12'h080);
        flags();
        chk(q, 32'h0);
        rd(`OFS_MASK);
        chk(q, 32'h0);
        rd(`OFS_THRESHOLD);
        chk(q, 32'h7FFF);
        chk(motor_code, exp_motor(1'b0, filter_drive));
        rd(5'h1C);
        chk(q, 32'h0);
        // Width selects, busy refusal, soft reset
        cmd(`CMD_WIDTH_TWELVE);
        chk(width_twelve, 1'b1);
        chk(motor_code, exp_motor(1'b1, filter_drive));
        wait_idle();
        wr(`OFS_CMD_STATUS, `CMD_WIDTH_EIGHT);
        wr(`OFS_CMD_STATUS, `CMD_WIDTH_TWELVE);
        wait_idle();
        chk(width_twelve, 1'b0);
        cmd(`CMD_RESET);
        cmd(`CMD_WIDTH_TWELVE);
        chk(width_twelve, 1'b1);
        // Home
        p = 32'($random(seed));
        set_raw(p);
        cmd(`CMD_HOME_DEFINE);
        chk(abs_position, 32'h0);
        x = 32'($random(seed)) & 32'h0000FFFF;
        set_raw(p + x);
        chk(abs_position, x);
        // Mask and flags
        m = (8'($random(seed)) | 8'h04) & 8'hEF;
        cmd(`CMD_MASK_LOAD);
        word({8'hFF, m});
        rd(`OFS_MASK);
        chk(q, {24'h0, m & 8'h7E});
        @(posedge core_clk);
        {traj_done_evt, wrap_evt, cmd_err_evt} <= 3'h7;
        @(posedge core_clk);
        {traj_done_evt, wrap_evt, cmd_err_evt} <= 3'h0;
        repeat (3) @(posedge core_clk);
        ef = 32'h16;
        flags();
        chk(q, ef);
        chk(host_irq, |(m & ef[7:0]));
        foreach (bits[i]) begin
            cmd(`CMD_FLAG_CLEAR);
            word({8'h00, ~(8'h01 << bits[i])});
            ef = ef & ~(32'h1 << bits[i]);
            flags();
            chk(q, ef);
            chk(host_irq, |(m & ef[7:0]));
        end
        // Error threshold, flag only then stop
        t = 16'($random(seed)) & 16'h7FFE;
        cmd(`CMD_THR_FLAG);
        word(t);
        rd(`OFS_THRESHOLD);
        chk(q, {16'h0, t});
        position_error <= -$signed(t);
        repeat (4) @(posedge core_clk);
        flags();
        chk(q, 32'h0);
        position_error <= $signed(t + 16'h1);
        repeat (4) @(posedge core_clk);
        flags();
        chk(q, 32'h20);
        rd(`OFS_CONFIG);
        chk(q & 32'hF, 32'h1);
        position_error <= 16'sh0000;
        cmd(`CMD_THR_STOP);
        word(t);
        position_error <= -$signed(t + 16'h1);
        repeat (4) @(posedge core_clk);
        position_error <= 16'sh0000;
        rd(`OFS_CONFIG);
        chk(q & 32'hC, 32'hC);
        chk(motor_code, 12'h800);
        cmd(`CMD_FLAG_CLEAR);
        word(16'h0000);
        cmd(`CMD_THR_FLAG);
        word(16'h7FFF);
        filter_drive <= 16'($random(seed));
        repeat (2) @(posedge core_clk);
        chk(motor_code, exp_motor(1'b1, filter_drive));
        // Index capture
        x = (32'($random(seed)) & 32'h0FFFFF00) | 32'hF0;
        set_raw(x);
        cmd(`CMD_INDEX_ARM);
        move <= 1'b1;
        for (int n = 0; n < 2000 && q[`BIT_INDEX] !== 1'b1; n++) flags();
        move <= 1'b0;
        if (q[`BIT_INDEX] !== 1'b1) fail_out();
        chk(q, 32'h08);
        rd(`OFS_INDEX_POS);
        chk(q, (x | 32'hFF) + 32'h1 - p);
        cmd(`CMD_FLAG_CLEAR);
        word(16'h0000);
        // Absolute and relative breakpoints
        b = 32'($random(seed)) & 32'h0FFFFFFF;
        cmd(`CMD_BP_ABS);
        word(b[31:16]);
        word(b[15:0]);
        rd(`OFS_BREAKPOINT);
        chk(q, b);
        set_raw(b + p);
        flags();
        chk(q, 32'h40);
        chk(host_irq, m[6]);
        cmd(`CMD_FLAG_CLEAR);
        word(16'h0000);
        target_position <= 32'($random(seed)) & 32'h0FFFFFFF;
        o = 32'($random(seed)) & 32'h000FFFFF;
        cmd(`CMD_BP_REL);
        word(o[31:16]);
        word(o[15:0]);
        rd(`OFS_BREAKPOINT);
        chk(q, target_position + o);
        set_raw(target_position + o + p);
        flags();
        chk(q, 32'h40);
        test_done();
    end
endmodule : testbench
